// ---- logic/txw_pkg.sv ----
// Constants, types and helpers shared by the transmit write/select port.
// Assumes a 16-bit link data bus and a single-port device with a 3-bit own address.
package txw_pkg;

    // ****************************************
    // Widths and addresses
    // ****************************************
    localparam int DATA_W = 16;
    localparam int ADDR_W = 3;
    localparam logic [2:0] NULL_PORT_ADDR = 3'h7;
    localparam logic [2:0] ADDR_RST = 3'h7;

    // ****************************************
    // Cell and store geometry
    // ****************************************
    localparam int CELL_OCTETS = 53;
    // Words per cell on the 16-bit bus, last word padded
    localparam int CELL_WORDS = (CELL_OCTETS + 1) / 2;
    localparam logic [7:0] CELL_WORDS_P = 8'(CELL_WORDS);
    localparam logic [4:0] CELL_LAST_IDX = 5'(CELL_WORDS - 1);
    localparam logic [4:0] IDX_RST = 5'h00;
    localparam int STORE_AW = 7;
    localparam int STORE_W = 17;
    localparam logic [7:0] STORE_DEPTH_P = 8'h80;
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [7:0] PKT_AVAIL_SPACE = 8'h08;
    localparam logic [15:0] IDLE_WORD = 16'h0000;

    // ****************************************
    // Modes and states
    // ****************************************
    typedef enum logic [1:0] {
        MODE_CELL = 2'b00,
        MODE_PKT_BYTE = 2'b01,
        MODE_PKT_LEVEL = 2'b10
    } txw_mode_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_CELL = 2'b01,
        RD_FILL = 2'b10,
        RD_PKT = 2'b11
    } txw_rd_state_t;

    function automatic logic [7:0] txw_bin2gray(input logic [7:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [7:0] txw_gray2bin(input logic [7:0] g);
        logic [7:0] b;
        b[7] = g[7];
        for (int i = 6; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction

endpackage

// ---- logic/txw_sync2.sv ----
// Two-flop level synchroniser, one stage pair per bit.
// Assumes each bit is a level or a gray-coded word bit.
`timescale 1ns/10ps
module txw_sync2 #(
    parameter int WIDTH = 1
) (
    // Destination clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    // ****************************************
    // Per-bit stages
    // ****************************************
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta_ff;
        logic hold_ff;
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                meta_ff <= 1'b0;
                hold_ff <= 1'b0;
            end else begin
                meta_ff <= d[i];
                hold_ff <= meta_ff;
            end
        end
        assign q[i] = hold_ff;
    end

endmodule

// ---- logic/txw_cell_store.sv ----
// Dual-clock word store for transmit cells and packet words.
// Assumes the writer never overwrites a slot the reader has not released.
`timescale 1ns/10ps
module txw_cell_store (
    // Write side, link clock
    input wire logic wr_clk,
    input wire logic wr_en,
    input wire logic [txw_pkg::STORE_AW-1:0] wr_addr,
    input wire logic [txw_pkg::STORE_W-1:0] wr_data,
    // Read side, system clock
    input wire logic rd_clk,
    input wire logic [txw_pkg::STORE_AW-1:0] rd_addr,
    output logic [txw_pkg::STORE_W-1:0] rd_data
);
    import txw_pkg::*;

    logic [STORE_W-1:0] mem [0:(1 << STORE_AW)-1];

    // ****************************************
    // Storage
    // ****************************************
    always_ff @(posedge wr_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge rd_clk) begin
        rd_data <= mem[rd_addr];
    end

endmodule

// ---- logic/txw_write_select_port.sv ----
// Transmit write/select port of a multi-PHY parallel interface, cell and packet modes.
// Assumes the link clock is free running and the strap inputs stay fixed while traffic flows.
`timescale 1ns/10ps
module txw_write_select_port (
    // System clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Link clock and write inputs
    input wire logic tx_interface_clock,
    input wire logic tx_write_enable_n,
    input wire logic [txw_pkg::ADDR_W-1:0] tx_port_address,
    input wire logic [txw_pkg::DATA_W-1:0] tx_data_bus,
    input wire logic tx_packet_start_mark,
    // Static straps
    input wire logic [txw_pkg::ADDR_W-1:0] own_port_address,
    input wire logic [1:0] port_mode,
    // Availability outputs, link clock
    output logic tx_cell_available,
    output logic tx_cell_available_oe,
    output logic polled_packet_available,
    output logic polled_packet_available_oe,
    output logic selected_packet_available,
    output logic direct_packet_available,
    // Outgoing transmit stream, system clock
    output logic [txw_pkg::DATA_W-1:0] tx_stream_word,
    output logic tx_stream_valid,
    output logic tx_stream_first,
    output logic tx_stream_idle
);
    import txw_pkg::*;

    // ****************************************
    // Link domain reset and straps
    // ****************************************
    logic [1:0] lrst_ff;
    wire link_rst_n = lrst_ff[1];

    always_ff @(posedge tx_interface_clock or negedge arst_n) begin
        if (!arst_n) begin
            lrst_ff <= 2'b00;
        end else begin
            lrst_ff <= {lrst_ff[0], 1'b1};
        end
    end

    logic [4:0] l_strap;
    logic [1:0] m_mode;

    txw_sync2 #(.WIDTH(5)) u_lstrap (
        .clk(tx_interface_clock),
        .rst_n(link_rst_n),
        .d({port_mode, own_port_address}),
        .q(l_strap)
    );
    txw_sync2 #(.WIDTH(2)) u_mmode (
        .clk(mclk),
        .rst_n(arst_n),
        .d(port_mode),
        .q(m_mode)
    );

    wire [2:0] l_own = l_strap[2:0];
    wire l_cell = l_strap[4:3] == MODE_CELL;
    wire l_byte = l_strap[4:3] == MODE_PKT_BYTE;
    wire l_level = !l_cell && !l_byte;
    wire m_cell = m_mode == MODE_CELL;

    // ****************************************
    // Link input sampling
    // ****************************************
    logic smp_wen_n_ff;
    logic [2:0] smp_addr_ff;
    logic [15:0] smp_data_ff;
    logic smp_sop_ff;
    logic [2:0] lat_addr_ff;

    always_ff @(posedge tx_interface_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            smp_wen_n_ff <= 1'b1;
            smp_addr_ff <= ADDR_RST;
            smp_data_ff <= IDLE_WORD;
            smp_sop_ff <= 1'b0;
        end else begin
            smp_wen_n_ff <= tx_write_enable_n;
            smp_addr_ff <= tx_port_address;
            smp_data_ff <= tx_data_bus;
            smp_sop_ff <= tx_packet_start_mark;
        end
    end

    always_ff @(posedge tx_interface_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lat_addr_ff <= ADDR_RST;
        end else if (smp_wen_n_ff && !l_byte) begin
            lat_addr_ff <= smp_addr_ff;
        end
    end

    // ****************************************
    // Selection and write decode
    // ****************************************
    logic [7:0] wr_ptr_ff;
    logic [7:0] commit_ptr_ff;
    logic [7:0] commit_gray_ff;
    logic [4:0] cell_idx_ff;
    logic [7:0] rd_gray_l;
    logic [7:0] pub_ptr_ff;
    logic [STORE_AW-1:0] rd_addr;
    logic [STORE_W-1:0] rd_data;

    wire addr_is_own = smp_addr_ff == l_own && smp_addr_ff != NULL_PORT_ADDR;
    wire lat_is_own = lat_addr_ff == l_own && lat_addr_ff != NULL_PORT_ADDR;
    wire [7:0] rd_bin_l = txw_gray2bin(rd_gray_l);
    wire [7:0] used_l = wr_ptr_ff - rd_bin_l;
    wire [7:0] space_l = STORE_DEPTH_P - used_l;
    wire store_full = used_l == STORE_DEPTH_P;
    // Byte level uses the current address
    wire sel_for_write = l_byte ? addr_is_own : lat_is_own;
    // Enabled word goes to the selected port unless the store is full
    wire wr_take = !smp_wen_n_ff && sel_for_write && !store_full;
    // Start mark gated by write and selection
    wire sop_take = wr_take && smp_sop_ff;
    wire cell_last = cell_idx_ff == CELL_LAST_IDX;
    wire word_first = l_cell ? cell_idx_ff == IDX_RST : sop_take;
    wire [7:0] nxt_wr_ptr = wr_ptr_ff + {7'h00, wr_take};
    wire commit_now = wr_take && (!l_cell || cell_last);
    wire [7:0] nxt_commit_ptr = commit_now ? nxt_wr_ptr : commit_ptr_ff;
    // Published pointer steps by one so its gray code changes one bit per edge
    wire [7:0] nxt_pub_ptr = pub_ptr_ff + {7'h00, pub_ptr_ff != commit_ptr_ff};
    wire [4:0] nxt_cell_idx = !(wr_take && l_cell) ? cell_idx_ff : cell_last ? IDX_RST : cell_idx_ff + 5'h01;
    wire cell_room = space_l >= CELL_WORDS_P;
    wire pkt_room = space_l >= PKT_AVAIL_SPACE;

    always_ff @(posedge tx_interface_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            wr_ptr_ff <= PTR_RST;
            commit_ptr_ff <= PTR_RST;
            commit_gray_ff <= PTR_RST;
            pub_ptr_ff <= PTR_RST;
            cell_idx_ff <= IDX_RST;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            commit_ptr_ff <= nxt_commit_ptr;
            pub_ptr_ff <= nxt_pub_ptr;
            commit_gray_ff <= txw_bin2gray(nxt_pub_ptr);
            cell_idx_ff <= nxt_cell_idx;
        end
    end

    txw_cell_store u_store (
        .wr_clk(tx_interface_clock),
        .wr_en(wr_take),
        .wr_addr(wr_ptr_ff[STORE_AW-1:0]),
        .wr_data({word_first, smp_data_ff}),
        .rd_clk(mclk),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    // ****************************************
    // Availability outputs
    // ****************************************
    always_ff @(posedge tx_interface_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_cell_available <= 1'b0;
            tx_cell_available_oe <= 1'b0;
            polled_packet_available <= 1'b0;
            polled_packet_available_oe <= 1'b0;
            selected_packet_available <= 1'b0;
            direct_packet_available <= 1'b0;
        end else begin
            tx_cell_available <= l_cell && cell_room;
            tx_cell_available_oe <= l_cell && lat_is_own;
            polled_packet_available <= l_level && pkt_room;
            polled_packet_available_oe <= l_level && addr_is_own;
            selected_packet_available <= l_level && lat_is_own && pkt_room;
            direct_packet_available <= l_byte && pkt_room;
        end
    end

    // ****************************************
    // Pointer crossings
    // ****************************************
    logic [7:0] commit_gray_m;
    logic [7:0] rd_ptr_ff;
    logic [7:0] rd_gray_ff;

    txw_sync2 #(.WIDTH(8)) u_commit_sync (
        .clk(mclk),
        .rst_n(arst_n),
        .d(commit_gray_ff),
        .q(commit_gray_m)
    );
    txw_sync2 #(.WIDTH(8)) u_rd_sync (
        .clk(tx_interface_clock),
        .rst_n(link_rst_n),
        .d(rd_gray_ff),
        .q(rd_gray_l)
    );

    // ****************************************
    // Transmit stream sequencer
    // ****************************************
    txw_rd_state_t state_ff;
    txw_rd_state_t nxt_state;
    logic [4:0] word_idx_ff;
    logic [4:0] nxt_word_idx;
    logic do_read;
    logic emit_idle;
    logic issue_ff;
    logic idle_ff;
    logic idle_first_ff;

    wire [7:0] avail_m = txw_gray2bin(commit_gray_m) - rd_ptr_ff;
    wire idx_last = word_idx_ff == CELL_LAST_IDX;
    wire [7:0] nxt_rd_ptr = rd_ptr_ff + {7'h00, do_read};
    assign rd_addr = rd_ptr_ff[STORE_AW-1:0];

    always_comb begin
        nxt_state = state_ff;
        nxt_word_idx = word_idx_ff;
        do_read = 1'b0;
        emit_idle = 1'b0;
        case (state_ff)
            RD_IDLE: begin
                nxt_word_idx = IDX_RST;
                if (!m_cell) begin
                    nxt_state = RD_PKT;
                end else if (avail_m >= CELL_WORDS_P) begin
                    nxt_state = RD_CELL;
                end else begin
                    nxt_state = RD_FILL;
                end
            end
            RD_CELL, RD_FILL: begin
                do_read = state_ff == RD_CELL;
                emit_idle = state_ff == RD_FILL;
                nxt_word_idx = idx_last ? IDX_RST : word_idx_ff + 5'h01;
                if (idx_last) begin
                    nxt_state = RD_IDLE;
                end
            end
            RD_PKT: begin
                do_read = avail_m != PTR_RST;
                if (m_cell) begin
                    nxt_state = RD_IDLE;
                end
            end
            default: begin
                nxt_state = RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= RD_IDLE;
            word_idx_ff <= IDX_RST;
            rd_ptr_ff <= PTR_RST;
            rd_gray_ff <= PTR_RST;
            issue_ff <= 1'b0;
            idle_ff <= 1'b0;
            idle_first_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            word_idx_ff <= nxt_word_idx;
            rd_ptr_ff <= nxt_rd_ptr;
            rd_gray_ff <= txw_bin2gray(nxt_rd_ptr);
            issue_ff <= do_read;
            idle_ff <= emit_idle;
            idle_first_ff <= emit_idle && word_idx_ff == IDX_RST;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tx_stream_word <= IDLE_WORD;
            tx_stream_valid <= 1'b0;
            tx_stream_first <= 1'b0;
            tx_stream_idle <= 1'b0;
        end else begin
            tx_stream_word <= issue_ff ? rd_data[DATA_W-1:0] : IDLE_WORD;
            tx_stream_valid <= issue_ff || idle_ff;
            tx_stream_first <= issue_ff ? rd_data[DATA_W] : idle_first_ff;
            tx_stream_idle <= idle_ff;
        end
    end

endmodule

// ---- sim/txw_write_select_port_props.sv ----
// Checker for the transmit write/select port, bound to its top module.
// Assumes straps are set while reset is held.
`timescale 1ns/10ps
module txw_write_select_port_props
    import txw_pkg::*;
(
    // Clocks and reset
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic tx_interface_clock,
    // Link inputs and straps
    input wire logic tx_write_enable_n,
    input wire logic [ADDR_W-1:0] tx_port_address,
    input wire logic [ADDR_W-1:0] own_port_address,
    input wire logic [1:0] port_mode,
    // Availability outputs
    input wire logic tx_cell_available_oe,
    input wire logic polled_packet_available_oe,
    input wire logic selected_packet_available,
    input wire logic direct_packet_available,
    // Stream outputs
    input wire logic [DATA_W-1:0] tx_stream_word,
    input wire logic tx_stream_valid,
    input wire logic tx_stream_first,
    input wire logic tx_stream_idle
);
    // ********
    // Helpers
    // ********
    logic [7:0] word_cnt_ff;
    logic [7:0] nxt_word_cnt;
    wire own_sel = (tx_port_address == own_port_address) && (tx_port_address != NULL_PORT_ADDR);
    wire cell_mode = (port_mode == 2'h0);
    wire lvl_mode = (port_mode == 2'h2);
    assign nxt_word_cnt = tx_stream_first ? 8'h01 : word_cnt_ff + 8'h01;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            word_cnt_ff <= 8'h00;
        end else if (tx_stream_valid) begin
            word_cnt_ff <= nxt_word_cnt;
        end
    end
    sequence s_cell_head;
        cell_mode && tx_stream_valid && tx_stream_first;
    endsequence
    sequence s_cell_body;
        (tx_stream_valid && !tx_stream_first) [*8];
    endsequence
    // ********
    // Assertions
    // ********
    // foreign floats
    AST_CELL_OE_FOREIGN: assert property (@(posedge tx_interface_clock) disable iff (!arst_n)
        cell_mode && tx_write_enable_n && !own_sel |-> ##[1:3] !tx_cell_available_oe)
        else $error("cell available driven for a foreign latched address");
    AST_CELL_OE_OWN: assert property (@(posedge tx_interface_clock) disable iff (!arst_n)
        cell_mode && tx_write_enable_n && own_sel |-> ##[1:3] tx_cell_available_oe)
        else $error("cell available not driven for own address");
    AST_BYTE_NO_POLL: assert property (@(posedge tx_interface_clock) disable iff (!arst_n)
        port_mode == 2'h1 && $past(port_mode, 8) == 2'h1
        |-> !polled_packet_available_oe && !selected_packet_available && !tx_cell_available_oe)
        else $error("polled output active in byte level");
    AST_DIRECT_BYTE_ONLY: assert property (@(posedge tx_interface_clock) disable iff (!arst_n)
        port_mode != 2'h1 && $past(port_mode, 8) == port_mode |-> !direct_packet_available)
        else $error("direct available outside byte level");
    AST_PKT_POLL_OWN: assert property (@(posedge tx_interface_clock) disable iff (!arst_n)
        lvl_mode && own_sel |-> ##[1:3] polled_packet_available_oe)
        else $error("polled output not driven for own address");
    AST_PKT_POLL_OTHER: assert property (@(posedge tx_interface_clock) disable iff (!arst_n)
        lvl_mode && !own_sel |-> ##[1:3] !polled_packet_available_oe)
        else $error("polled output driven for foreign address");
    AST_SEL_FOREIGN: assert property (@(posedge tx_interface_clock) disable iff (!arst_n)
        lvl_mode && tx_write_enable_n && !own_sel |-> ##[1:3] !selected_packet_available)
        else $error("selected status high for foreign port");
    AST_CELL_HEAD: assert property (@(posedge mclk) disable iff (!arst_n)
        s_cell_head |=> s_cell_body)
        else $error("cell words not consecutive");
    AST_CELL_LEN: assert property (@(posedge mclk) disable iff (!arst_n)
        s_cell_head and (word_cnt_ff != 8'h00) |-> word_cnt_ff == CELL_WORDS_P)
        else $error("cell length wrong");
    AST_IDLE_ZERO: assert property (@(posedge mclk) disable iff (!arst_n)
        tx_stream_valid && tx_stream_idle |-> tx_stream_word == IDLE_WORD)
        else $error("idle cell word not zero");
endmodule

bind txw_write_select_port txw_write_select_port_props i_props (
    .mclk, .arst_n, .tx_interface_clock, .tx_write_enable_n, .tx_port_address, .own_port_address,
    .port_mode, .tx_cell_available_oe, .polled_packet_available_oe, .selected_packet_available,
    .direct_packet_available, .tx_stream_word, .tx_stream_valid, .tx_stream_first, .tx_stream_idle
);

// ---- sim/txw_link_writer.sv ----
// Writer model for the link side, one write-group cycle per link edge.
// Assumes the bench calls cyc and the link clock runs free.
`timescale 1ns/10ps
module txw_link_writer (
    // Link clock
    input wire logic clk,
    // Write group
    output logic en_n,
    output logic [2:0] addr,
    output logic [15:0] data,
    output logic mark
);
    initial begin
        en_n = 1'b1;
        addr = 3'h7;
        data = 16'h0000;
        mark = 1'b0;
    end
    task automatic cyc(input logic e, input logic [2:0] a, input logic [15:0] d, input logic m);
        @(posedge clk);
        en_n <= e;
        addr <= a;
        data <= e ? ~data : d;
        mark <= m;
    endtask
endmodule

// ---- sim/tb_txw_write_select_port.sv ----
// Testbench for the transmit write/select port in all three modes.
// Assumes the link writer model and the bound checker.
`timescale 1ns/10ps
module tb_txw_write_select_port;
    import txw_pkg::*;
    logic mclk = 1'b0;
    logic lclk = 1'b0;
    logic arst_n = 1'b0;
    logic [2:0] own_port_address = 3'h0;
    logic [1:0] port_mode = 2'h0;
    logic en_n, mark, cell_av, cell_oe, poll_av, poll_oe, sel_av, dir_av, s_valid, s_first, s_idle;
    logic [2:0] addr;
    logic [15:0] data, s_word;
    logic [16:0] got_q[$];
    int idle_words = 0;
    int fail_count = 0;
    int samples_checked = 0;

    always #25 mclk = ~mclk;
    always #24 lclk = ~lclk;

    txw_link_writer i_wr (.clk(lclk), .en_n(en_n), .addr(addr), .data(data), .mark(mark));
    txw_write_select_port i_dut (
        .mclk(mclk), .arst_n(arst_n), .tx_interface_clock(lclk), .tx_write_enable_n(en_n),
        .tx_port_address(addr), .tx_data_bus(data), .tx_packet_start_mark(mark),
        .own_port_address(own_port_address), .port_mode(port_mode), .tx_cell_available(cell_av),
        .tx_cell_available_oe(cell_oe), .polled_packet_available(poll_av), .polled_packet_available_oe(poll_oe),
        .selected_packet_available(sel_av), .direct_packet_available(dir_av), .tx_stream_word(s_word),
        .tx_stream_valid(s_valid), .tx_stream_first(s_first), .tx_stream_idle(s_idle)
    );

    // Collects data words and counts idle words
    always @(posedge mclk) begin
        if (s_valid === 1'b1 && s_idle === 1'b1) idle_words++;
        if (s_valid === 1'b1 && s_idle === 1'b0) got_q.push_back({s_first, s_word});
    end

    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic end_sim();
        $display("Counts: %0d compared, %0d mismatched", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic do_reset(input logic [1:0] m, input logic [2:0] a);
        arst_n <= 1'b0;
        port_mode <= m;
        own_port_address <= a;
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (12) @(posedge lclk);
        got_q.delete();
        idle_words = 0;
    endtask

    // Enable high cycles on one address, then settle
    task automatic hold(input logic [2:0] a, input int n);
        repeat (n) i_wr.cyc(1'b1, a, 16'h0000, 1'b0);
        @(negedge lclk);
    endtask

    task automatic burst(input logic [2:0] a, input logic [15:0] base, input int n);
        for (int i = 0; i < n; i++) i_wr.cyc(1'b0, a, base + 16'(i), 1'b0);
    endtask

    // Waits for the words, then compares them in order
    task automatic expect_q(input logic [16:0] e[$]);
        for (int i = 0; i < 3000 && got_q.size() < e.size(); i++) @(posedge mclk);
        if (got_q.size() < e.size()) begin
            $display("Error at %0t ns: got %h expected %h", $time, got_q.size(), e.size());
            fail_count++;
            end_sim();
        end
        repeat (100) @(posedge mclk);
        check(17'(got_q.size()), 17'(e.size()));
        foreach (e[i]) check(got_q[i], e[i]);
    endtask

    task automatic test_cell();
        logic [16:0] e[$];
        for (int i = 0; i < CELL_WORDS; i++) e.push_back({i == 0, 16'h1000 + 16'(i)});
        do_reset(2'h0, 3'h3);
        repeat (120) @(posedge mclk);
        check(17'(idle_words > 0), 17'h1);
        hold(3'h7, 1);
        burst(3'h3, 16'h2000, CELL_WORDS);
        hold(3'h5, 1);
        burst(3'h3, 16'h3000, CELL_WORDS);
        hold(3'h3, 5);
        check(17'(cell_oe), 17'h1);
        check(17'(cell_av), 17'h1);
        burst(3'h5, 16'h1000, 26);
        hold(3'h3, 5);
        repeat (200) @(posedge mclk);
        check(17'(got_q.size()), 17'h0);
        burst(3'h3, 16'h101a, 1);
        hold(3'h5, 5);
        check(17'(cell_oe), 17'h0);
        expect_q(e);
        $display("test_cell done");
    endtask

    task automatic test_byte();
        do_reset(2'h1, 3'h2);
        hold(3'h2, 5);
        check({15'h0, dir_av, poll_oe}, 17'h2);
        i_wr.cyc(1'b1, 3'h2, 16'h0000, 1'b1);
        i_wr.cyc(1'b0, 3'h2, 16'ha000, 1'b1);
        i_wr.cyc(1'b0, 3'h4, 16'hb000, 1'b1);
        i_wr.cyc(1'b0, 3'h2, 16'ha001, 1'b0);
        i_wr.cyc(1'b0, 3'h7, 16'hc000, 1'b1);
        i_wr.cyc(1'b1, 3'h2, 16'h0000, 1'b1);
        i_wr.cyc(1'b0, 3'h2, 16'ha002, 1'b1);
        hold(3'h7, 2);
        expect_q('{17'h1a000, 17'h0a001, 17'h1a002});
        $display("test_byte done");
    endtask

    task automatic test_pkt();
        do_reset(2'h2, 3'h6);
        hold(3'h6, 5);
        check({15'h0, poll_oe, sel_av}, 17'h3);
        check(17'(poll_av), 17'h1);
        i_wr.cyc(1'b0, 3'h6, 16'hd000, 1'b1);
        i_wr.cyc(1'b0, 3'h1, 16'hd001, 1'b0);
        i_wr.cyc(1'b0, 3'h1, 16'hd002, 1'b0);
        hold(3'h1, 5);
        check({15'h0, poll_oe, sel_av}, 17'h0);
        i_wr.cyc(1'b0, 3'h6, 16'hd003, 1'b1);
        hold(3'h7, 3);
        expect_q('{17'h1d000, 17'h0d001, 17'h0d002});
        $display("test_pkt done");
    endtask

    initial begin
        test_cell();
        test_byte();
        test_pkt();
        end_sim();
    end
endmodule
